/* design/branch_cfg.svh */
// Purpose: Constants for the conditional relative branch execution block.
// Assumes: 16-bit program counter, 8-bit opcodes and displacements.
// Notes:   Included by the package and by the design modules.
`ifndef BRANCH_CFG_SVH
`define BRANCH_CFG_SVH
`define PC_WIDTH          16
`define OPC_TEST_CLEAR    8'h10
`define OPC_CARRY         8'h40
`define LEN_TEST_CLEAR    16'h0003
`define LEN_CARRY         16'h0002
`define MACHINE_CYCLES    2
`endif

/* design/branch_pkg.sv */
// Purpose: Types shared by the branch execution modules.
// Assumes: branch_cfg.svh holds the numeric constants.
// Notes:   Holds the instruction kind enumeration and the sequencer states.
`include "branch_cfg.svh"
package branch_pkg;
    typedef enum logic [1:0] {KIND_NONE, KIND_TEST_CLEAR, KIND_CARRY} branch_kind_e;
    typedef enum logic [1:0] {ST_IDLE, ST_CYCLE2} branch_state_e;
    typedef logic [`PC_WIDTH-1:0] pc_t;
endpackage

/* design/rel_target_calc.sv */
// Purpose: Branch target adder for relative displacements.
// Assumes: Program counter points at the opcode of the current instruction.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "branch_cfg.svh"
module rel_target_calc
    import branch_pkg::*;
(
    input  wire logic [`PC_WIDTH-1:0] pc_in,
    input  wire logic [15:0]          len_in,
    input  wire logic [7:0]           rel_in,
    output logic      [`PC_WIDTH-1:0] next_out,
    output logic      [`PC_WIDTH-1:0] target_out
);
    logic [`PC_WIDTH-1:0] rel_ext;

    // Sign extension and wrapping add; carries out of the top bit are dropped on purpose.
    always_comb
    begin
        rel_ext    = {{(`PC_WIDTH-8){rel_in[7]}}, rel_in};
        next_out   = pc_in + len_in[`PC_WIDTH-1:0];
        target_out = next_out + rel_ext;
    end
endmodule
`default_nettype wire

/* design/cond_branch_exec.sv */
// Purpose: Executes the test-and-clear bit branch and the carry branch.
// Assumes: Decode presents opcode and operand bytes with a one-cycle start pulse.
// Notes:   Each instruction takes two machine cycles; the result shows at the end.
//          A start that arrives while an instruction is in flight is ignored; the
//          fetch side may present the next opcode in the cycle that done shows.
//
// What this block does
// - Set bit: clear it and branch.
// - Zero bit: no write at all.
// - Target is PC plus three plus rel.
// - Program status flags never change here.
// - Port bits read from output latch.
// - Opcode 10h, three bytes, two cycles.
// - Carry set: branch, else fall through.
// - Carry target is PC plus two plus rel.
// - Opcode 40h, two bytes, two cycles.
`timescale 1ns/1ps
`default_nettype none
`include "branch_cfg.svh"
module cond_branch_exec
    import branch_pkg::*;
(
    input  wire logic                 sys_clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic                 start_in,
    input  wire logic [7:0]           opcode_in,
    input  wire logic [7:0]           bit_addr_in,
    input  wire logic [7:0]           rel_b2_in,
    input  wire logic [7:0]           rel_b3_in,
    input  wire logic [`PC_WIDTH-1:0] pc_in,
    input  wire logic                 carry_in,
    input  wire logic                 bit_val_in,
    input  wire logic                 bit_is_port_in,
    input  wire logic                 port_latch_val_in,
    output logic                      accepted_out,
    output logic                      bit_read_out,
    output logic [7:0]                bit_addr_out,
    output logic                      bit_wr_out,
    output logic                      bit_wr_val_out,
    output logic                      done_out,
    output logic                      pc_load_out,
    output logic [`PC_WIDTH-1:0]      pc_new_out,
    output logic                      psw_wr_out
);
    // Sequencer state, captured operands, the sampled condition and the commit results.
    branch_state_e         state_r, state_nxt;
    branch_kind_e          kind_r, kind_nxt;
    logic [`PC_WIDTH-1:0]  next_r, next_nxt;
    logic [`PC_WIDTH-1:0]  tgt_r, tgt_nxt;
    logic [7:0]            addr_r, addr_nxt;
    logic                  cond_r, cond_nxt;
    logic                  done_r, done_nxt;
    logic                  load_r, load_nxt;
    logic [`PC_WIDTH-1:0]  pcn_r, pcn_nxt;
    logic                  wr_r, wr_nxt;
    logic [`PC_WIDTH-1:0]  calc_next;
    logic [`PC_WIDTH-1:0]  calc_tgt;
    logic [15:0]           len_sel;
    logic [7:0]            rel_sel;
    branch_kind_e          kind_dec;
    logic                  take;
    logic                  commit;

    // Shared decode of the opcode byte.
    function automatic branch_kind_e decode_kind(input logic [7:0] op);
        if (op == `OPC_TEST_CLEAR)
            return KIND_TEST_CLEAR;
        else if (op == `OPC_CARRY)
            return KIND_CARRY;
        else
            return KIND_NONE;
    endfunction

    // Operand selection: displacement sits in byte three or byte two.
    always_comb
    begin
        kind_dec = decode_kind(opcode_in);
        if (kind_dec == KIND_TEST_CLEAR)
        begin
            len_sel = `LEN_TEST_CLEAR;
            rel_sel = rel_b3_in;
        end
        else
        begin
            len_sel = `LEN_CARRY;
            rel_sel = rel_b2_in;
        end
    end

    rel_target_calc u_calc (
        .pc_in      (pc_in),
        .len_in     (len_sel),
        .rel_in     (rel_sel),
        .next_out   (calc_next),
        .target_out (calc_tgt)
    );

    // A start is taken only while idle and only for one of the two opcodes.
    // Unknown opcodes are left for the rest of the decoder.
    assign take   = (state_r == ST_IDLE) && start_in && (kind_dec != KIND_NONE);
    // The second machine cycle is the commit cycle.
    assign commit = (state_r == ST_CYCLE2);

    // Sequencer: the first cycle captures operands and the condition, the second commits.
    // The condition is sampled with the start, so a later change of the bit cannot steer the branch.
    always_comb
    begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        next_nxt  = next_r;
        tgt_nxt   = tgt_r;
        addr_nxt  = addr_r;
        cond_nxt  = cond_r;
        case (state_r)
            ST_IDLE:
            begin
                if (take)
                begin
                    state_nxt = ST_CYCLE2;
                    kind_nxt  = kind_dec;
                    next_nxt  = calc_next;
                    tgt_nxt   = calc_tgt;
                    addr_nxt  = bit_addr_in;
                    if (kind_dec == KIND_TEST_CLEAR)
                        cond_nxt = bit_is_port_in ? port_latch_val_in : bit_val_in;
                    else
                        cond_nxt = carry_in;
                end
            end
            ST_CYCLE2:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers; reset leaves the sequencer idle.
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            state_r <= ST_IDLE;
            kind_r  <= KIND_NONE;
            next_r  <= '0;
            tgt_r   <= '0;
            addr_r  <= 8'h00;
            cond_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            next_r  <= next_nxt;
            tgt_r   <= tgt_nxt;
            addr_r  <= addr_nxt;
            cond_r  <= cond_nxt;
        end
    end

    // Commit results: pulses last one cycle, the new program counter holds until the next commit.
    // Holding both candidate addresses in registers keeps the adder off the load path.
    always_comb
    begin
        done_nxt = 1'b0;
        load_nxt = 1'b0;
        pcn_nxt  = pcn_r;
        wr_nxt   = 1'b0;
        if (commit)
        begin
            done_nxt = 1'b1;
            load_nxt = 1'b1;
            pcn_nxt  = cond_r ? tgt_r : next_r;
            wr_nxt   = (kind_r == KIND_TEST_CLEAR) && cond_r;
        end
    end

    // Commit registers; a reset in mid-instruction drops the pending write.
    // The bit space therefore keeps its old value when the core is reset between cycles.
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            done_r <= 1'b0;
            load_r <= 1'b0;
            pcn_r  <= '0;
            wr_r   <= 1'b0;
        end
        else
        begin
            done_r <= done_nxt;
            load_r <= load_nxt;
            pcn_r  <= pcn_nxt;
            wr_r   <= wr_nxt;
        end
    end

    // Accept and bit-read strobes are combinational; done, load, write, address and new PC outputs come from flip-flops.
    assign accepted_out   = take;
    assign bit_read_out   = accepted_out && (kind_dec == KIND_TEST_CLEAR);
    assign bit_addr_out   = addr_r;
    assign bit_wr_out     = wr_r;
    assign bit_wr_val_out = 1'b0;
    assign done_out       = done_r;
    assign pc_load_out    = load_r;
    assign pc_new_out     = pcn_r;
    assign psw_wr_out     = 1'b0;
endmodule
`default_nettype wire

/* testbench/bit_space_model.sv */
// Purpose: Bit-addressable space seen by the branch block.
// Assumes: Writes come from the block's registered write pulse.
// Notes:   Starts with a mixed pattern so both outcomes occur.
`timescale 1ns/1ps
`default_nettype none
module bit_space_model
(
    input  wire logic       clk_in,
    input  wire logic [7:0] rd_addr_in,
    input  wire logic [7:0] wr_addr_in,
    input  wire logic       wr_in,
    input  wire logic       wr_val_in,
    output logic            val_out
);
    logic [255:0] mem_r = {32{8'hA5}};
    // Bits are stored on the write pulse and read back at once.
    always @(posedge clk_in)
        if (wr_in) mem_r[wr_addr_in] <= wr_val_in;
    assign val_out = mem_r[rd_addr_in];
endmodule
`default_nettype wire

/* testbench/cond_branch_props.sv */
// Purpose: Port assertions for the branch block.
// Assumes: One clock, synchronous reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
`include "branch_cfg.svh"
module cond_branch_props
(
    input wire logic                 sys_clk_in,
    input wire logic                 sys_rst_in,
    input wire logic [7:0]           opcode_in,
    input wire logic [7:0]           rel_b2_in,
    input wire logic [7:0]           rel_b3_in,
    input wire logic [`PC_WIDTH-1:0] pc_in,
    input wire logic                 carry_in,
    input wire logic                 bit_val_in,
    input wire logic                 bit_is_port_in,
    input wire logic                 port_latch_val_in,
    input wire logic                 accepted_out,
    input wire logic                 bit_wr_out,
    input wire logic                 bit_wr_val_out,
    input wire logic                 done_out,
    input wire logic                 pc_load_out,
    input wire logic [`PC_WIDTH-1:0] pc_new_out,
    input wire logic                 psw_wr_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic tc, cb, hit;
    logic [`PC_WIDTH-1:0] t3, t2;
    // Port bits must come from the latch, so the condition follows that choice.
    assign hit = bit_is_port_in ? port_latch_val_in : bit_val_in;
    assign tc = accepted_out && opcode_in == 8'h10;
    assign cb = accepted_out && opcode_in == 8'h40;
    assign t3 = pc_in + 16'h0003 + (hit ? {{8{rel_b3_in[7]}}, rel_b3_in} : 16'h0000);
    assign t2 = pc_in + 16'h0002 + (carry_in ? {{8{rel_b2_in[7]}}, rel_b2_in} : 16'h0000);
    property p_lat; accepted_out |-> ##2 done_out; endproperty
    a_lat: assert property (p_lat) else $error("done not two cycles after accept");
    property p_pair; done_out == pc_load_out; endproperty
    a_pair: assert property (p_pair) else $error("load and done differ");
    property p_set; tc && hit |-> ##2 bit_wr_out; endproperty
    a_set: assert property (p_set) else $error("set bit not cleared");
    property p_zero; tc && !hit |-> ##2 !bit_wr_out; endproperty
    a_zero: assert property (p_zero) else $error("zero bit written");
    property p_val; bit_wr_out |-> !bit_wr_val_out; endproperty
    a_val: assert property (p_val) else $error("bit written with one");
    property p_flag; !psw_wr_out; endproperty
    a_flag: assert property (p_flag) else $error("flags written");
    property p_tc; tc |-> ##2 pc_new_out == $past(t3, 2); endproperty
    a_tc: assert property (p_tc) else $error("bad test-clear target");
    property p_cb; cb |-> ##2 pc_new_out == $past(t2, 2); endproperty
    a_cb: assert property (p_cb) else $error("bad carry target");
    property p_busy; accepted_out |=> !accepted_out; endproperty
    a_busy: assert property (p_busy) else $error("start taken while busy");
    c_set: cover property (tc && hit);
    c_cy: cover property (cb && carry_in);
    c_nc: cover property (cb && !carry_in);
endmodule
bind cond_branch_exec cond_branch_props cond_branch_props_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .opcode_in(opcode_in), .rel_b2_in(rel_b2_in), .rel_b3_in(rel_b3_in), .pc_in(pc_in), .carry_in(carry_in),
    .bit_val_in(bit_val_in), .bit_is_port_in(bit_is_port_in), .port_latch_val_in(port_latch_val_in),
    .accepted_out(accepted_out), .bit_wr_out(bit_wr_out), .bit_wr_val_out(bit_wr_val_out), .done_out(done_out),
    .pc_load_out(pc_load_out), .pc_new_out(pc_new_out), .psw_wr_out(psw_wr_out));
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: Random and corner tests of the branch block.
// Assumes: 125 MHz clock, reset held 16 cycles.
// Notes:   Expected targets are worked out by a bench function.
`timescale 1ns/1ps
`default_nettype none
module testbench import branch_pkg::*;;
    logic clk = 0, rst = 1, st = 0, cy = 0, prt = 0, lat = 0, bv;
    logic [7:0] op = 0, ba = 0, r2 = 0, r3 = 0, bao;
    pc_t pc = 0, pn;
    logic acc, rd, wr, wv, dn, ld, psw;
    int fails = 0, cmp_count = 0;
    cond_branch_exec cond_branch_exec_i (.sys_clk_in(clk), .sys_rst_in(rst), .start_in(st), .opcode_in(op),
        .bit_addr_in(ba), .rel_b2_in(r2), .rel_b3_in(r3), .pc_in(pc), .carry_in(cy), .bit_val_in(bv),
        .bit_is_port_in(prt), .port_latch_val_in(lat), .accepted_out(acc), .bit_read_out(rd),
        .bit_addr_out(bao), .bit_wr_out(wr), .bit_wr_val_out(wv), .done_out(dn), .pc_load_out(ld),
        .pc_new_out(pn), .psw_wr_out(psw));
    bit_space_model bit_space_model_i (.clk_in(clk), .rd_addr_in(ba), .wr_addr_in(bao), .wr_in(wr),
        .wr_val_in(wv), .val_out(bv));
    // Free-running core clock.
    initial forever #4 clk = ~clk;
    function automatic pc_t exp_pc(logic [7:0] o, pc_t p, logic [7:0] b2, logic [7:0] b3, logic c);
        exp_pc = o == 8'h10 ? p + 16'h0003 + (c ? {{8{b3[7]}}, b3} : 16'h0000)
                            : p + 16'h0002 + (c ? {{8{b2[7]}}, b2} : 16'h0000);
    endfunction
    task automatic chk(logic [31:0] g, logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task results;
        $display("fails %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One instruction; after a known opcode a start while busy is thrown in at random to prove it is ignored.
    task automatic run(logic [7:0] o, pc_t p, logic [7:0] r);
        logic k, h;
        pc_t e;
        @(posedge clk);
        st  <= 1'b1;
        op  <= o;
        pc  <= p;
        r2  <= r;
        r3  <= ~r;
        ba  <= 8'($urandom);
        cy  <= 1'($urandom);
        prt <= 1'($urandom);
        lat <= 1'($urandom);
        #1 k = o == 8'h10 || o == 8'h40;
        h = o == 8'h10 ? (prt ? lat : bv) : cy;
        e = exp_pc(o, p, r, ~r, h);
        chk(acc, k);
        chk(rd, o == 8'h10);
        @(posedge clk);
        st <= k & 1'($urandom);
        op <= 8'h40;
        #1 chk(acc, 1'b0);
        @(posedge clk);
        st <= 0;
        #1 chk(dn, k);
        chk(ld, k);
        if (k) chk(pn, e);
        if (k) chk(bao, ba);
        chk(wr, o == 8'h10 && h);
        chk(wv, 1'b0);
        chk(psw, 0);
    endtask
    // Corner cases with wrapping targets and an unknown opcode first, then random traffic.
    initial
    begin
        void'($urandom(32'h8EF1));
        repeat (16) @(posedge clk);
        rst <= 0;
        run(8'h10, 16'hFFFF, 8'h7F);
        run(8'h40, 16'h0000, 8'h80);
        run(8'h11, 16'h1234, 8'h01);
        repeat (300) run($urandom % 3 == 0 ? 8'($urandom) : ($urandom % 2 ? 8'h10 : 8'h40), 16'($urandom), 8'($urandom));
        // A reset in mid-instruction must drop the pending commit and clear the new address.
        @(posedge clk);
        st <= 1'b1;
        op <= 8'h40;
        cy <= 1'b1;
        @(posedge clk);
        st  <= 1'b0;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1 chk(dn, 1'b0);
        chk(pn, 16'h0000);
        run(8'h10, 16'h8000, 8'h05);
        results;
    end
    // Cuts a hang short well past the expected run length.
    initial
    begin
        #50000;
        fails++;
        results;
    end
endmodule
`default_nettype wire
